// *** serial_line_model.sv ***
// Serial line partner: drives the receive line, captures transmit frames
`timescale 1ns/1ps
module serial_line_model (
  input wire logic hclk,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic dt_pin_out,
  input wire logic dt_pin_oe,
  output logic rx_pin_in
);
  logic rx_drv = 1'b1;
  // Pull-up holds the line high when nobody drives it
  assign rx_pin_in = dt_pin_oe ? dt_pin_out : rx_drv;
  // Odd phase offset keeps line edges away from clock edges
  task automatic send_bits(input logic [13:0] v, input int n, input real t);
    begin
      #0.7;
      for (int i = 0; i < n; i++)
      begin
        rx_drv = v[i];
        #(t);
      end
      rx_drv = 1'b1;
    end
  endtask
  // Returns at mid stop bit so a following start edge is seen fresh
  task automatic get_async(input int n, output logic [13:0] f, output bit ok);
    int k;
    begin
      f = '0;
      k = 0;
      while (tx_pin_out !== 1'b0 && k < 4000)
      begin
        @(posedge hclk);
        k++;
      end
      ok = (k < 4000) && (tx_pin_oe === 1'b1);
      repeat (8) @(posedge hclk);
      for (int i = 0; i < n; i++)
      begin
        f[i] = tx_pin_out;
        if (i < n - 1)
          repeat (16) @(posedge hclk);
      end
    end
  endtask
  // Data is taken where the clock leaves its idle level
  task automatic get_sync(input logic cpol, input int n, output logic [13:0] f, output bit ok);
    int k;
    begin
      f = '0;
      ok = 1'b1;
      for (int i = 0; i < n; i++)
      begin
        k = 0;
        while (tx_pin_out === cpol && k < 400)
        begin
          @(posedge hclk);
          k++;
        end
        if (k >= 400 || dt_pin_oe !== 1'b1)
          ok = 1'b0;
        f[i] = dt_pin_out;
        k = 0;
        while (tx_pin_out !== cpol && k < 400)
        begin
          @(posedge hclk);
          k++;
        end
      end
    end
  endtask
endmodule

// *** serial_port.sv ***
// Serial port: wake-on-edge, break send, synchronous master transmit
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
module serial_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleep_mode,
  input wire logic rx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic dt_pin_out,
  output logic dt_pin_oe,
  output logic receive_flag,
  output logic transmit_flag
);
  serial_port_pkg::state_s st_ff;
  serial_port_pkg::state_s nxt_st;
  logic instr_tick;
  logic baud_tick;
  logic bit_end;
  logic rx_line;
  logic fall;
  logic rise;
  logic sync_master;
  logic tx_load;
  logic rf_set;
  logic wr_baud;
  logic [4:0] os_top;
  logic [7:0] w;

  function automatic logic [7:0] read_reg(input serial_port_pkg::state_s s);
    case (s.addr)
      `OFS_RCV_STATUS: read_reg = {s.port_enable, 7'h00};
      `OFS_TX_BUFFER: read_reg = s.tx_buf;
      `OFS_RCV_BUFFER: read_reg = s.rcv_buf;
      `OFS_TX_STATUS: read_reg = {s.clock_source_select, s.nine_bit_transmit,
        s.transmit_enable, s.sync_mode, s.send_break_request, s.high_speed,
        s.txs == serial_port_pkg::TX_IDLE, s.ninth_transmit_bit};
      `OFS_BAUD_CTRL: read_reg = {1'b0, s.rxs == serial_port_pkg::RX_IDLE, 1'b0,
        s.clock_polarity_select, s.wide_divider_select, 1'b0,
        s.wake_on_edge_enable, s.autobaud_enable};
      `OFS_DIV_HIGH: read_reg = s.div_hi;
      `OFS_DIV_LOW: read_reg = s.div_lo;
      `OFS_FLAGS: read_reg = {6'h00, ~s.tx_full, s.receive_flag};
      // The shift register has no address at all
      default: read_reg = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    w = hwdata[7:0];
    nxt_st.rx_sync = {st_ff.rx_sync[1:0], rx_pin_in};
    rx_line = st_ff.rx_sync[1];
    fall = st_ff.rx_sync[2] & ~st_ff.rx_sync[1];
    rise = ~st_ff.rx_sync[2] & st_ff.rx_sync[1];
    sync_master = st_ff.sync_mode & st_ff.clock_source_select;
    os_top = st_ff.high_speed ? `OS_FAST_TOP : `OS_NORMAL_TOP;
    // Instruction cycle is four clocks; baud counts instruction cycles
    instr_tick = st_ff.q_cnt == `INSTR_LAST;
    nxt_st.q_cnt = st_ff.q_cnt + 2'h1;
    baud_tick = instr_tick && st_ff.baud_cnt == 16'h0000;
    if (instr_tick)
    begin
      if (baud_tick)
        nxt_st.baud_cnt = st_ff.wide_divider_select ? {st_ff.div_hi, st_ff.div_lo}
          : {8'h00, st_ff.div_lo};
      else
        nxt_st.baud_cnt = st_ff.baud_cnt - 16'h0001;
    end
    bit_end = baud_tick && st_ff.tx_os == 5'h00;
    wr_baud = st_ff.wr_pend && st_ff.addr == `OFS_BAUD_CTRL;
    rf_set = 1'b0;

    // Transmit shifter
    tx_load = instr_tick && st_ff.txs == serial_port_pkg::TX_IDLE && st_ff.tx_full
      && st_ff.port_enable && st_ff.transmit_enable
      && !(st_ff.sync_mode && st_ff.rxs != serial_port_pkg::RX_IDLE);
    unique case (st_ff.txs)
      serial_port_pkg::TX_IDLE:
      begin
        if (tx_load)
        begin
          nxt_st.tx_full = 1'b0;
          nxt_st.tx_os = os_top;
          nxt_st.sh_brk = 1'b0;
          if (st_ff.sync_mode)
          begin
            nxt_st.sh = {5'h00, st_ff.ninth_transmit_bit, st_ff.tx_buf};
            nxt_st.sh_len = st_ff.nine_bit_transmit ? `LEN_SYNC9 : `LEN_SYNC8;
            nxt_st.txs = serial_port_pkg::TX_SYNC_LO;
          end
          else if (st_ff.send_break_request)
          begin
            // Buffer contents are dropped, frame is 13 zeros then a one stop bit
            nxt_st.sh = `BREAK_FRAME;
            nxt_st.sh_len = `LEN_BREAK;
            nxt_st.sh_brk = 1'b1;
            nxt_st.txs = serial_port_pkg::TX_ASYNC;
          end
          else
          begin
            nxt_st.sh = st_ff.nine_bit_transmit
              ? {4'hF, st_ff.ninth_transmit_bit, st_ff.tx_buf, 1'b0}
              : {5'h1F, st_ff.tx_buf, 1'b0};
            nxt_st.sh_len = st_ff.nine_bit_transmit ? `LEN_ASYNC9 : `LEN_ASYNC8;
            nxt_st.txs = serial_port_pkg::TX_ASYNC;
          end
        end
      end
      serial_port_pkg::TX_ASYNC:
      begin
        if (baud_tick)
          nxt_st.tx_os = bit_end ? os_top : st_ff.tx_os - 5'h01;
        if (bit_end)
        begin
          nxt_st.sh = {1'b1, st_ff.sh[13:1]};
          nxt_st.sh_len = st_ff.sh_len - 4'h1;
          if (st_ff.sh_len == 4'h1)
          begin
            nxt_st.txs = serial_port_pkg::TX_IDLE;
            nxt_st.sh_len = 4'h0;
            if (st_ff.sh_brk)
              nxt_st.send_break_request = 1'b0;
          end
        end
      end
      serial_port_pkg::TX_SYNC_LO:
      begin
        if (baud_tick)
          nxt_st.txs = serial_port_pkg::TX_SYNC_HI;
      end
      serial_port_pkg::TX_SYNC_HI:
      begin
        if (baud_tick)
        begin
          // One bit per clock period, lowest first
          nxt_st.sh = {1'b0, st_ff.sh[13:1]};
          nxt_st.sh_len = st_ff.sh_len - 4'h1;
          nxt_st.txs = serial_port_pkg::TX_SYNC_LO;
          if (st_ff.sh_len == 4'h1)
          begin
            nxt_st.txs = serial_port_pkg::TX_IDLE;
            nxt_st.sh_len = 4'h0;
          end
        end
      end
    endcase
    if (!st_ff.transmit_enable || !st_ff.port_enable)
    begin
      // Dropping the enable aborts the word in flight
      nxt_st.txs = serial_port_pkg::TX_IDLE;
      nxt_st.sh_len = 4'h0;
    end

    // Asynchronous receiver, held idle while waiting for a wake edge
    if (st_ff.wake_on_edge_enable || !st_ff.port_enable || st_ff.sync_mode)
      nxt_st.rxs = serial_port_pkg::RX_IDLE;
    else if (st_ff.rxs == serial_port_pkg::RX_IDLE)
    begin
      if (fall)
      begin
        nxt_st.rxs = serial_port_pkg::RX_START;
        nxt_st.rx_os = {1'b0, os_top[4:1]};
        nxt_st.rx_bits = 4'h0;
      end
    end
    else if (baud_tick)
    begin
      nxt_st.rx_os = st_ff.rx_os - 5'h01;
      if (st_ff.rx_os == 5'h00)
      begin
        nxt_st.rx_os = os_top;
        unique case (st_ff.rxs)
          serial_port_pkg::RX_START:
            nxt_st.rxs = rx_line ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
          serial_port_pkg::RX_DATA:
          begin
            nxt_st.rx_sh = {rx_line, st_ff.rx_sh[7:1]};
            nxt_st.rx_bits = st_ff.rx_bits + 4'h1;
            if (st_ff.rx_bits == 4'h7)
              nxt_st.rxs = serial_port_pkg::RX_STOP;
          end
          serial_port_pkg::RX_STOP:
          begin
            // Byte after a wake edge pair arrives here too
            nxt_st.rcv_buf = st_ff.rx_sh;
            rf_set = 1'b1;
            nxt_st.rxs = serial_port_pkg::RX_IDLE;
          end
          serial_port_pkg::RX_IDLE:
            nxt_st.rxs = serial_port_pkg::RX_IDLE;
        endcase
      end
    end

    // Wake-on-edge: falling edge flags, following rising edge disarms
    if (st_ff.wake_on_edge_enable)
    begin
      if (fall && !st_ff.wake_seen)
      begin
        nxt_st.wake_seen = 1'b1;
        nxt_st.wake_pend = 1'b1;
        nxt_st.rcv_buf = 8'h00;
      end
      if (st_ff.wake_pend && (sleep_mode || instr_tick))
      begin
        nxt_st.wake_pend = 1'b0;
        rf_set = 1'b1;
      end
      if (rise && st_ff.wake_seen && !st_ff.wake_pend)
      begin
        nxt_st.wake_on_edge_enable = 1'b0;
        nxt_st.wake_seen = 1'b0;
      end
    end
    else
    begin
      nxt_st.wake_seen = 1'b0;
      nxt_st.wake_pend = 1'b0;
    end

    // Bus slave: zero-wait writes, reads take one wait state
    nxt_st.wr_pend = 1'b0;
    nxt_st.hresp = 1'b0;
    if (st_ff.rd_pend)
    begin
      nxt_st.rd_pend = 1'b0;
      nxt_st.hready = 1'b1;
      nxt_st.hrdata = {24'h000000, read_reg(st_ff)};
      if (st_ff.addr == `OFS_RCV_BUFFER)
        nxt_st.receive_flag = 1'b0;
    end
    if (st_ff.wr_pend)
    begin
      unique case (st_ff.addr)
        `OFS_RCV_STATUS: nxt_st.port_enable = w[7];
        `OFS_TX_BUFFER:
        begin
          nxt_st.tx_buf = w;
          nxt_st.tx_full = 1'b1;
        end
        `OFS_TX_STATUS:
        begin
          nxt_st.clock_source_select = w[7];
          nxt_st.nine_bit_transmit = w[6];
          nxt_st.transmit_enable = w[5];
          nxt_st.sync_mode = w[4];
          nxt_st.send_break_request = w[3];
          nxt_st.high_speed = w[2];
          nxt_st.ninth_transmit_bit = w[0];
        end
        `OFS_BAUD_CTRL:
        begin
          nxt_st.clock_polarity_select = w[4];
          nxt_st.wide_divider_select = w[3];
          nxt_st.wake_on_edge_enable = w[1];
          nxt_st.autobaud_enable = w[0];
        end
        `OFS_DIV_HIGH: nxt_st.div_hi = w;
        `OFS_DIV_LOW: nxt_st.div_lo = w;
        default: nxt_st.hresp = 1'b0;
      endcase
    end
    if (hsel && htrans[1] && hready)
    begin
      nxt_st.addr = haddr[7:0];
      nxt_st.wr_pend = hwrite;
      nxt_st.rd_pend = !hwrite;
      nxt_st.hready = hwrite;
    end
    // Hardware set wins over a same-cycle read clear
    if (rf_set)
      nxt_st.receive_flag = 1'b1;
    // Registered copy so the flag pin comes straight from a flop
    nxt_st.buf_empty = ~nxt_st.tx_full;

    // Pins follow the mode
    nxt_st.tx_oe = st_ff.port_enable && (sync_master || st_ff.transmit_enable);
    nxt_st.dt_oe = st_ff.port_enable && sync_master && st_ff.transmit_enable
      && st_ff.txs != serial_port_pkg::TX_IDLE;
    nxt_st.dt_out = st_ff.sh[0];
    if (sync_master)
      nxt_st.tx_out = (st_ff.txs == serial_port_pkg::TX_SYNC_HI)
        ? ~st_ff.clock_polarity_select : st_ff.clock_polarity_select;
    else
      nxt_st.tx_out = (st_ff.txs == serial_port_pkg::TX_ASYNC) ? st_ff.sh[0] : 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff <= '0;
      st_ff.hready <= 1'b1;
      st_ff.tx_out <= 1'b1;
      st_ff.rx_sync <= 3'h7;
      st_ff.buf_empty <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign hreadyout = st_ff.hready;
  assign hresp = st_ff.hresp;
  assign hrdata = st_ff.hrdata;
  assign tx_pin_out = st_ff.tx_out;
  assign tx_pin_oe = st_ff.tx_oe;
  assign dt_pin_out = st_ff.dt_out;
  assign dt_pin_oe = st_ff.dt_oe;
  assign receive_flag = st_ff.receive_flag;
  assign transmit_flag = st_ff.buf_empty;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  break_zeros_a: assert property (
    st_ff.txs == serial_port_pkg::TX_ASYNC && st_ff.sh_brk && st_ff.sh_len != 4'h1
    && st_ff.port_enable && !st_ff.sync_mode |=> tx_pin_out == 1'b0)
    else $error("break frame bit not zero");
  break_len_a: assert property (
    tx_load && st_ff.send_break_request && !st_ff.sync_mode
    |=> st_ff.sh_len == `LEN_BREAK && st_ff.sh_brk)
    else $error("break frame length wrong");
  send_break_request_clear_a: assert property (
    bit_end && st_ff.sh_brk && st_ff.sh_len == 4'h1 && st_ff.txs == serial_port_pkg::TX_ASYNC
    && st_ff.transmit_enable && st_ff.port_enable && !st_ff.wr_pend
    |=> !st_ff.send_break_request)
    else $error("send-break not cleared after break");
  load_flag_a: assert property (
    tx_load && !st_ff.wr_pend |=> transmit_flag && st_ff.txs != serial_port_pkg::TX_IDLE)
    else $error("load did not free buffer");
  txbuf_write_a: assert property (
    st_ff.wr_pend && st_ff.addr == `OFS_TX_BUFFER |=> !transmit_flag)
    else $error("buffer write left transmit flag set");
  txflag_hold_a: assert property (
    transmit_flag && !(st_ff.wr_pend && st_ff.addr == `OFS_TX_BUFFER) |=> transmit_flag)
    else $error("transmit flag cleared without write");
  no_reload_a: assert property (
    st_ff.txs != serial_port_pkg::TX_IDLE |=> st_ff.sh_len <= $past(st_ff.sh_len))
    else $error("shift register reloaded mid word");
  wake_idle_a: assert property (
    st_ff.wake_on_edge_enable |=> st_ff.rxs == serial_port_pkg::RX_IDLE)
    else $error("receiver active under wake enable");
  wake_flag_a: assert property (
    st_ff.wake_on_edge_enable && fall && !st_ff.wake_seen && !wr_baud
    |-> ##[2:5] st_ff.receive_flag)
    else $error("wake edge did not raise receive flag");
  wake_clear_a: assert property (
    st_ff.wake_on_edge_enable && rise && st_ff.wake_seen && !st_ff.wake_pend && !wr_baud
    |=> !st_ff.wake_on_edge_enable)
    else $error("wake enable not cleared on rising edge");
  rcv_read_a: assert property (
    st_ff.rd_pend && st_ff.addr == `OFS_RCV_BUFFER && !rf_set |=> !receive_flag)
    else $error("receive buffer read kept flag");
  half_duplex_a: assert property (
    st_ff.sync_mode && st_ff.txs != serial_port_pkg::TX_IDLE |-> st_ff.rxs == serial_port_pkg::RX_IDLE)
    else $error("receive during synchronous transmit");
  clock_idle_a: assert property (
    sync_master && st_ff.txs == serial_port_pkg::TX_IDLE
    |=> tx_pin_out == $past(st_ff.clock_polarity_select))
    else $error("shift clock idle level wrong");

  break_sent_c: cover property (bit_end && st_ff.sh_brk && st_ff.sh_len == 4'h1);
  wake_event_c: cover property (st_ff.wake_seen ##[1:200] !st_ff.wake_on_edge_enable);
  sync_word_c: cover property (st_ff.txs == serial_port_pkg::TX_SYNC_HI && st_ff.sh_len == 4'h1);
  rcv_read_c: cover property (st_ff.rd_pend && st_ff.addr == `OFS_RCV_BUFFER && receive_flag);
endmodule

// *** serial_port_cfg.svh ***
// Constants for the serial port with break and synchronous master transmit
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH
`define OFS_RCV_STATUS 8'h00
`define OFS_TX_BUFFER 8'h04
`define OFS_RCV_BUFFER 8'h08
`define OFS_TX_STATUS 8'h0C
`define OFS_BAUD_CTRL 8'h10
`define OFS_DIV_HIGH 8'h14
`define OFS_DIV_LOW 8'h18
`define OFS_FLAGS 8'h1C
`define REG_RESET 8'h00
`define OS_NORMAL_TOP 5'h0F
`define OS_FAST_TOP 5'h03
`define INSTR_LAST 2'h3
`define BREAK_FRAME 14'h2000
`define LEN_BREAK 4'hE
`define LEN_ASYNC8 4'hA
`define LEN_ASYNC9 4'hB
`define LEN_SYNC8 4'h8
`define LEN_SYNC9 4'h9
`endif

// *** serial_port_pkg.sv ***
// Types for the serial port block
package serial_port_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_ASYNC = 2'b01, TX_SYNC_LO = 2'b10,
    TX_SYNC_HI = 2'b11} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
    RX_STOP = 2'b11} rx_state_e;
  typedef struct packed {
    logic [2:0] rx_sync;
    logic [1:0] q_cnt;
    logic [15:0] baud_cnt;
    logic port_enable;
    logic clock_source_select;
    logic nine_bit_transmit;
    logic transmit_enable;
    logic sync_mode;
    logic send_break_request;
    logic high_speed;
    logic ninth_transmit_bit;
    logic clock_polarity_select;
    logic wide_divider_select;
    logic wake_on_edge_enable;
    logic autobaud_enable;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic [7:0] tx_buf;
    logic tx_full;
    logic buf_empty;
    logic [13:0] sh;
    logic [3:0] sh_len;
    logic sh_brk;
    logic [4:0] tx_os;
    tx_state_e txs;
    logic [7:0] rcv_buf;
    logic receive_flag;
    logic wake_seen;
    logic wake_pend;
    rx_state_e rxs;
    logic [4:0] rx_os;
    logic [3:0] rx_bits;
    logic [7:0] rx_sh;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic tx_out;
    logic tx_oe;
    logic dt_out;
    logic dt_oe;
  } state_s;
endpackage

// *** tb.sv ***
// Testbench for the serial port block
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sleep_mode = 1'b0;
  logic hreadyout, hresp, rx_pin_in, tx_pin_out, tx_pin_oe, dt_pin_out, dt_pin_oe;
  logic receive_flag, transmit_flag;
  logic [31:0] hrdata;
  int errors = 0;
  int check_count = 0;
  always #2.5 hclk = ~hclk;
  serial_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_mode(sleep_mode),
    .rx_pin_in(rx_pin_in), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .dt_pin_out(dt_pin_out), .dt_pin_oe(dt_pin_oe), .receive_flag(receive_flag),
    .transmit_flag(transmit_flag));
  serial_line_model i_model (.hclk(hclk), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
    .dt_pin_out(dt_pin_out), .dt_pin_oe(dt_pin_oe), .rx_pin_in(rx_pin_in));
  task automatic final_report();
    begin
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      check_count++;
      if (got !== exp)
      begin
        errors++;
        $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task automatic wait_ready();
    int n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
        @(posedge hclk);
        n++;
      end
      if (n >= 50)
      begin
        chk("hreadyout", 1'b1, hreadyout);
        final_report();
      end
    end
  endtask
  // Slave answers in its own time; 50 clocks without hreadyout end the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
      q = hrdata[7:0];
      chk("hresp", 1'b0, hresp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    begin
      bus(1'b1, a, d, q);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    logic [7:0] q;
    begin
      bus(1'b0, a, 8'h00, q);
      chk(what, e, q & m);
    end
  endtask
  task automatic wait_sig(input string what, input bit rx, input logic v, input int lim);
    int n;
    begin
      n = 0;
      while ((rx ? receive_flag : transmit_flag) !== v && n < lim)
      begin
        @(posedge hclk);
        n++;
      end
      chk(what, v, rx ? receive_flag : transmit_flag);
      if (n >= lim)
        final_report();
    end
  endtask
  task automatic test_regs();
    begin
      rd_chk("receive_status_control rst", `OFS_RCV_STATUS, 8'hFF, 8'h00);
      rd_chk("transmit_status_control rst", `OFS_TX_STATUS, 8'hFF, 8'h02);
      rd_chk("baud rst", `OFS_BAUD_CTRL, 8'hFF, 8'h40);
      rd_chk("flags rst", `OFS_FLAGS, 8'h03, 8'h02);
      wr(`OFS_DIV_HIGH, 8'hA5);
      rd_chk("div_hi", `OFS_DIV_HIGH, 8'hFF, 8'hA5);
      wr(`OFS_DIV_HIGH, 8'h00);
      wr(`OFS_BAUD_CTRL, 8'h19);
      rd_chk("baud rw", `OFS_BAUD_CTRL, 8'hFF, 8'h59);
      wr(`OFS_BAUD_CTRL, 8'h00);
      wr(8'h20, 8'hFF);
      rd_chk("unmapped", 8'h20, 8'hFF, 8'h00);
      wr(`OFS_RCV_BUFFER, 8'h77);
      rd_chk("receive_buffer ro", `OFS_RCV_BUFFER, 8'hFF, 8'h00);
      $display("test_regs done");
    end
  endtask
  task automatic test_break();
    logic [13:0] f1, f2;
    bit ok1, ok2;
    begin
      wr(`OFS_RCV_STATUS, 8'h80);
      wr(`OFS_TX_STATUS, 8'h2C);
      fork
        begin
          i_model.get_async(14, f1, ok1);
          i_model.get_async(10, f2, ok2);
        end
        begin
          wr(`OFS_TX_BUFFER, 8'hA5);
          @(posedge hclk);
          chk("transmit_flag on write", 1'b0, transmit_flag);
          wait_sig("transmit_flag on load", 1'b0, 1'b1, 8);
          wr(`OFS_TX_BUFFER, 8'h55);
          wr(`OFS_FLAGS, 8'h02);
          chk("transmit_flag sw set", 1'b0, transmit_flag);
          wr(`OFS_TX_STATUS, 8'h2E);
          rd_chk("transmit_status_control in break", `OFS_TX_STATUS, 8'hFF, 8'h2C);
          wait_sig("transmit_flag after break", 1'b0, 1'b1, 400);
          rd_chk("send_break_request cleared", `OFS_TX_STATUS, 8'h08, 8'h00);
        end
      join
      chk("line ok", 2'h3, {ok1, ok2});
      chk("break frame", 14'h2000, f1);
      chk("sync frame", 14'h02AA, f2);
      repeat (16) @(posedge hclk);
      rd_chk("transmit_status_control idle", `OFS_TX_STATUS, 8'hFF, 8'h26);
      wr(`OFS_TX_STATUS, 8'h00);
      $display("test_break done");
    end
  endtask
  task automatic test_sync();
    logic [13:0] f1, f2;
    bit ok1, ok2;
    begin
      // Divisor one gives an 80 ns shift clock
      wr(`OFS_DIV_LOW, 8'h01);
      rd_chk("div_lo", `OFS_DIV_LOW, 8'hFF, 8'h01);
      for (int p = 0; p < 2; p++)
      begin
        wr(`OFS_BAUD_CTRL, p[0] ? 8'h10 : 8'h00);
        wr(`OFS_TX_STATUS, p[0] ? 8'hF1 : 8'hB0);
        repeat (4) @(posedge hclk);
        chk("clock oe", 1'b1, tx_pin_oe);
        chk("clock idle", p[0], tx_pin_out);
        fork
          begin
            i_model.get_sync(p[0], 8 + p, f1, ok1);
            i_model.get_sync(p[0], 8 + p, f2, ok2);
          end
          begin
            wr(`OFS_TX_BUFFER, 8'h3C);
            @(posedge hclk);
            wait_sig("transmit_flag sync", 1'b0, 1'b1, 8);
            wr(`OFS_TX_BUFFER, 8'h96);
          end
        join
        chk("sync clocks", 2'h3, {ok1, ok2});
        chk("word 1", {5'h00, p[0], 8'h3C}, f1);
        chk("word 2", {5'h00, p[0], 8'h96}, f2);
        repeat (12) @(posedge hclk);
        chk("data oe off", 1'b0, dt_pin_oe);
        rd_chk("shift_empty_status sync", `OFS_TX_STATUS, 8'h02, 8'h02);
      end
      wr(`OFS_TX_STATUS, 8'h00);
      wr(`OFS_DIV_LOW, 8'h00);
      $display("test_sync done");
    end
  endtask
  task automatic test_wake();
    begin
      wr(`OFS_BAUD_CTRL, 8'h00);
      wr(`OFS_TX_STATUS, 8'h04);
      for (int s = 0; s < 2; s++)
      begin
        sleep_mode <= s[0];
        rd_chk("receiver_idle_flag", `OFS_BAUD_CTRL, 8'h40, 8'h40);
        wr(`OFS_BAUD_CTRL, 8'h02);
        fork
          i_model.send_bits(14'h2000, 14, 80.0);
          begin
            @(posedge hclk);
            wait_sig("wake flag", 1'b1, 1'b1, s ? 6 : 12);
            rd_chk("wue held", `OFS_BAUD_CTRL, 8'h02, 8'h02);
          end
        join
        sleep_mode <= 1'b0;
        repeat (8) @(posedge hclk);
        rd_chk("wue cleared", `OFS_BAUD_CTRL, 8'h02, 8'h00);
        rd_chk("wake byte", `OFS_RCV_BUFFER, 8'hFF, 8'h00);
        @(posedge hclk);
        chk("flag after read", 1'b0, receive_flag);
        fork
          i_model.send_bits({5'h1F, 8'hC3, 1'b0}, 10, 80.0);
          wait_sig("byte flag", 1'b1, 1'b1, 400);
        join
        rd_chk("byte", `OFS_RCV_BUFFER, 8'hFF, 8'hC3);
      end
      // Break sent 13/9 faster: stop edge lands where the receiver's stop bit begins, half a bit before its stop sample
      fork
        i_model.send_bits(14'h2000, 14, 80.0 * 9.0 / 13.0);
        wait_sig("break flag", 1'b1, 1'b1, 400);
      join
      rd_chk("break byte", `OFS_RCV_BUFFER, 8'hFF, 8'h00);
      $display("test_wake done");
    end
  endtask
  initial
  begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_regs();
    test_break();
    test_sync();
    test_wake();
    final_report();
  end
endmodule
